// ---- cic_cfg.svh ----
// Purpose: Offsets, field positions, reset values and fixed numbers.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes: Included by the controller only; the package holds the types.
`ifndef CIC_CFG_SVH
`define CIC_CFG_SVH
`define CIC_OFS_CTRL 5'h00
`define CIC_OFS_PE1 5'h04
`define CIC_OFS_PE2 5'h08
`define CIC_OFS_PR1 5'h0c
`define CIC_OFS_PR2 5'h10
`define CIC_OFS_MASK 5'h14
`define CIC_OFS_EDGE 5'h18
`define CIC_OFS_STAT 5'h1c
`define CIC_BIT_GIE 7
`define CIC_BIT_PERIPHERAL_GROUP_ENABLE 6
`define CIC_BIT_T0IE 5
`define CIC_BIT_EXIE 4
`define CIC_BIT_PBIE 3
`define CIC_BIT_T0IF 2
`define CIC_BIT_EXIF 1
`define CIC_BIT_PBIF 0
`define CIC_RST_CTRL 8'h00
`define CIC_RST_PE 8'h00
`define CIC_RST_PR 8'h00
`define CIC_RST_MASK 8'h00
`define CIC_RST_POL 1'h1
`define CIC_PR2_IMPL 8'hf1
`define CIC_VECTOR 13'h0004
`define CIC_WAKE_CORE 3'h3
`define CIC_WAKE_PE1 8'h7f
`define CIC_WAKE_PE2 8'h00
`endif

// ---- cic_pkg.sv ----
// Purpose: Types shared by the interrupt controller.
// Assumes: Constants come from cic_cfg.svh.
// Notes: The whole controller state is one packed struct.
package cic_pkg;
    typedef enum logic [1:0] {
        CIC_IDLE = 2'b00,
        CIC_ENTER = 2'b01,
        CIC_STEP = 2'b10
    } cic_st_e;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] pe1;
        logic [7:0] pe2;
        logic [7:0] pr1;
        logic [7:0] pr2;
        logic [7:0] mask;
        logic pol;
        logic ext_s1;
        logic ext_s2;
        logic ext_prev;
        logic [7:0] pb_s1;
        logic [7:0] pb_s2;
        logic [7:0] pb_prev;
        logic sleep_prev;
        cic_st_e st;
        logic flush;
        logic push;
        logic load;
        logic [12:0] push_val;
        logic [12:0] load_val;
        logic ack;
        logic [31:0] rdata;
    } cic_state_s;
endpackage : cic_pkg

// ---- cic_core_interrupt_controller.sv ----
// Purpose: Interrupt controller of an 8-bit core, Avalon-MM registers.
// Assumes: core_clk is the instruction-cycle clock; rst clears all but the polarity bit, which it sets.
// Notes: Stack, sleep controller and peripheral event logic sit outside.
// Notes on behaviour
// - Sixteen sources, each with its own request flag and enable bit.
// - Any reset clears the global enable, so all interrupts are off.
// - Redirect needs own enable and global; peripherals also group enable.
// - Flags set on their events whatever any enable bit says.
// - Entry flushes prefetch, clears global, pushes PC, loads vector 0004h.
// - A flag still set and enabled after return is taken again.
// - With global enable clear, flags set but no redirect happens.
// - Pending request is serviced once global enable is set again.
// - Return pops the saved address into PC and sets global enable.
// - Synchronous source reaches vector code three cycles after event.
// - Asynchronous source reaches the vector three or four cycles later; here the pin takes four or five, port-B change (via its flag) five or six.
// - Latency is the same for one- and two-cycle instructions.
// - External flag settable in the Q4-Q1 window, sampled once a cycle.
// - Only enabled sources that run without clock wake from sleep.
// - After wake, branch to vector if global set, else carry on.
// - The instruction after power-down always runs before the branch.
// - External pin is edge triggered; polarity bit set means rising.
// - Valid edge sets external flag; redirect also needs both enables.
// - Entry saves only the return PC; other core registers untouched.
// - Control register bit order: enables 7..3, flags 2..0, all writable.
// - Port-B flag sets on change of any masked pin, held until cleared.
// - Timer0 overflow sets its flag; the timer itself ignores reset.
// - Peripheral set one: gate1, adc, rx, tx, ssp, ccp1, tmr2, tmr1.
// - Peripheral set two: gate3, tmr3, tmrB, tmrA, bits 3-1 zero, ccp2.
//
// Local design decisions: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "cic_cfg.svh"

module cic_core_interrupt_controller
    import cic_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Event sources
    input wire logic timer0_ovf_event,
    input wire logic external_request_pin,
    input wire logic [7:0] portb_pins,
    input wire logic [7:0] periph_event_one,
    input wire logic [7:0] periph_event_two,
    // Instruction sequencer and stack
    input wire logic [12:0] current_pc,
    input wire logic return_from_service,
    input wire logic [12:0] stack_pop_addr,
    output logic flush_prefetch,
    output logic stack_push,
    output logic [12:0] stack_push_addr,
    output logic pc_load,
    output logic [12:0] pc_load_value,
    // Power-down controller
    input wire logic sleep_active,
    output logic wake_request
);
    cic_state_s s;
    cic_state_s next_s;

    logic bus_req;
    logic wr_en;
    logic ext_edge;
    logic pb_change;
    logic core_req;
    logic per_req;
    logic irq_take;
    logic wake_any;
    logic [31:0] rd_mux;

    // One wait state per access; the answer is registered.
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~s.ack;
    assign wr_en = avs_write & s.ack & avs_byteenable[0];

    // Edges are seen on the second synchroniser stage against a third.
    assign ext_edge = s.pol ? (s.ext_s2 & ~s.ext_prev)
                            : (~s.ext_s2 & s.ext_prev);
    assign pb_change = |((s.pb_s2 ^ s.pb_prev) & s.mask);

    // Core flags 2..0 pair with enables 5..3.
    assign core_req = |(s.ctrl[5:3] & s.ctrl[2:0]);
    assign per_req = s.ctrl[`CIC_BIT_PERIPHERAL_GROUP_ENABLE] &
                     (|(s.pe1 & s.pr1) | |(s.pe2 & s.pr2));
    // The external edge bypasses its flag so the pin path costs no
    // extra cycle beyond the synchroniser.
    assign irq_take = s.ctrl[`CIC_BIT_GIE] &
                      (core_req | per_req |
                       (s.ctrl[`CIC_BIT_EXIE] & ext_edge));

    // Wake ignores the global enable but needs the source's enables.
    assign wake_any = |(s.ctrl[5:3] & s.ctrl[2:0] & `CIC_WAKE_CORE) |
                      (s.ctrl[`CIC_BIT_PERIPHERAL_GROUP_ENABLE] &
                       (|(s.pe1 & s.pr1 & `CIC_WAKE_PE1) |
                        |(s.pe2 & s.pr2 & `CIC_WAKE_PE2)));
    assign wake_request = sleep_active & wake_any;

    assign avs_readdata = s.rdata;
    assign flush_prefetch = s.flush;
    assign stack_push = s.push;
    assign stack_push_addr = s.push_val;
    assign pc_load = s.load;
    assign pc_load_value = s.load_val;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (avs_address)
            `CIC_OFS_CTRL: rd_mux[7:0] = s.ctrl;
            `CIC_OFS_PE1: rd_mux[7:0] = s.pe1;
            `CIC_OFS_PE2: rd_mux[7:0] = s.pe2 & `CIC_PR2_IMPL;
            `CIC_OFS_PR1: rd_mux[7:0] = s.pr1;
            `CIC_OFS_PR2: rd_mux[7:0] = s.pr2 & `CIC_PR2_IMPL;
            `CIC_OFS_MASK: rd_mux[7:0] = s.mask;
            `CIC_OFS_EDGE: rd_mux[0] = s.pol;
            `CIC_OFS_STAT: rd_mux[3:0] = {s.st, wake_request, sleep_active};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_s = s;
        next_s.flush = 1'b0;
        next_s.push = 1'b0;
        next_s.load = 1'b0;
        next_s.ext_s1 = external_request_pin;
        next_s.ext_s2 = s.ext_s1;
        next_s.ext_prev = s.ext_s2;
        next_s.pb_s1 = portb_pins;
        next_s.pb_s2 = s.pb_s1;
        next_s.pb_prev = s.pb_s2;
        next_s.sleep_prev = sleep_active;

        next_s.ack = bus_req & ~s.ack;
        if (avs_read && !s.ack) begin
            next_s.rdata = rd_mux;
        end

        if (wr_en) begin
            case (avs_address)
                `CIC_OFS_CTRL: next_s.ctrl = avs_writedata[7:0];
                `CIC_OFS_PE1: next_s.pe1 = avs_writedata[7:0];
                `CIC_OFS_PE2: next_s.pe2 = avs_writedata[7:0]
                                           & `CIC_PR2_IMPL;
                `CIC_OFS_PR1: next_s.pr1 = avs_writedata[7:0];
                `CIC_OFS_PR2: next_s.pr2 = avs_writedata[7:0]
                                           & `CIC_PR2_IMPL;
                `CIC_OFS_MASK: next_s.mask = avs_writedata[7:0];
                `CIC_OFS_EDGE: next_s.pol = avs_writedata[0];
                default: next_s.ctrl = next_s.ctrl;
            endcase
        end

        // Events are ORed in after the bus write, so an event in the
        // cycle of a software clear still leaves its flag set.
        if (timer0_ovf_event) begin
            next_s.ctrl[`CIC_BIT_T0IF] = 1'b1;
        end
        if (ext_edge) begin
            next_s.ctrl[`CIC_BIT_EXIF] = 1'b1;
        end
        if (pb_change) begin
            next_s.ctrl[`CIC_BIT_PBIF] = 1'b1;
        end
        next_s.pr1 = next_s.pr1 | periph_event_one;
        next_s.pr2 = next_s.pr2 | (periph_event_two & `CIC_PR2_IMPL);

        case (s.st)
            CIC_IDLE: begin
                if (return_from_service) begin
                    next_s.load = 1'b1;
                    next_s.load_val = stack_pop_addr;
                    next_s.ctrl[`CIC_BIT_GIE] = 1'b1;
                end else if (s.sleep_prev && !sleep_active) begin
                    // Leaving sleep: one instruction runs first.
                    next_s.st = CIC_STEP;
                end else if (irq_take && !sleep_active) begin
                    // Fixed sequence from the decision onward, so the
                    // length of the current instruction never matters.
                    next_s.st = CIC_ENTER;
                    next_s.flush = 1'b1;
                    next_s.ctrl[`CIC_BIT_GIE] = 1'b0;
                end
            end
            CIC_STEP: begin
                // Back to idle; a pending enabled request is taken there
                // only when the global enable is set.
                next_s.st = CIC_IDLE;
            end
            CIC_ENTER: begin
                // Only the return PC is saved; nothing else is touched.
                next_s.push = 1'b1;
                next_s.push_val = current_pc;
                next_s.load = 1'b1;
                next_s.load_val = `CIC_VECTOR;
                next_s.st = CIC_IDLE;
            end
            default: begin
                next_s.st = CIC_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s.ctrl <= `CIC_RST_CTRL;
            s.pe1 <= `CIC_RST_PE;
            s.pe2 <= `CIC_RST_PE;
            s.pr1 <= `CIC_RST_PR;
            s.pr2 <= `CIC_RST_PR;
            s.mask <= `CIC_RST_MASK;
            s.pol <= `CIC_RST_POL;
            s.ext_s1 <= 1'b0;
            s.ext_s2 <= 1'b0;
            s.ext_prev <= 1'b0;
            s.pb_s1 <= 8'h00;
            s.pb_s2 <= 8'h00;
            s.pb_prev <= 8'h00;
            s.sleep_prev <= 1'b0;
            s.st <= CIC_IDLE;
            s.flush <= 1'b0;
            s.push <= 1'b0;
            s.load <= 1'b0;
            s.push_val <= 13'h0000;
            s.load_val <= 13'h0000;
            s.ack <= 1'b0;
            s.rdata <= 32'h0000_0000;
        end else begin
            s <= next_s;
        end
    end

    property p_entry_order;
        @(posedge core_clk) disable iff (rst)
        s.flush |-> !s.ctrl[`CIC_BIT_GIE]
            ##1 (s.push && s.load && s.load_val == `CIC_VECTOR);
    endproperty
    a_entry_order: assert property (p_entry_order)
        else $error("entry sequence out of order");

    property p_sync_latency;
        @(posedge core_clk) disable iff (rst)
        (timer0_ovf_event && s.ctrl[`CIC_BIT_GIE]
            && s.ctrl[`CIC_BIT_T0IE] && s.st == CIC_IDLE
            && !s.flush && !s.push && !avs_write)
        ##1 (s.st == CIC_IDLE && !avs_write && !return_from_service
            && !sleep_active && !s.sleep_prev)
        |-> ##1 s.flush ##1 (s.load && s.load_val == `CIC_VECTOR);
    endproperty
    a_sync_latency: assert property (p_sync_latency)
        else $error("synchronous latency not three cycles");

    property p_flag_sets;
        @(posedge core_clk) disable iff (rst)
        (timer0_ovf_event && periph_event_one[0])
            |=> (s.ctrl[`CIC_BIT_T0IF] && s.pr1[0]);
    endproperty
    a_flag_sets: assert property (p_flag_sets)
        else $error("event did not set its flag");

    property p_no_redirect;
        @(posedge core_clk) disable iff (rst)
        !s.ctrl[`CIC_BIT_GIE] |=> !s.flush;
    endproperty
    a_no_redirect: assert property (p_no_redirect)
        else $error("redirect with global enable clear");

    property p_return;
        @(posedge core_clk) disable iff (rst)
        (return_from_service && s.st == CIC_IDLE) |=>
            (s.load && s.load_val == $past(stack_pop_addr)
             && s.ctrl[`CIC_BIT_GIE] && !s.push);
    endproperty
    a_return: assert property (p_return)
        else $error("return did not restore pc and enable");

    property p_portb_change;
        @(posedge core_clk) disable iff (rst)
        pb_change |=> s.ctrl[`CIC_BIT_PBIF] ##1 (s.ctrl[`CIC_BIT_PBIF]
            || $past(wr_en && avs_address == `CIC_OFS_CTRL));
    endproperty
    a_portb_change: assert property (p_portb_change)
        else $error("port-B change flag missed");

    property p_ext_edge;
        @(posedge core_clk) disable iff (rst)
        ($rose(s.ext_s2) && s.pol) |-> ##1 s.ctrl[`CIC_BIT_EXIF];
    endproperty
    a_ext_edge: assert property (p_ext_edge)
        else $error("rising edge did not set external flag");

    property p_wake_step;
        @(posedge core_clk) disable iff (rst)
        (s.sleep_prev && !sleep_active && s.st == CIC_IDLE
            && !return_from_service)
        |=> (s.st == CIC_STEP && !s.flush) ##1 (!s.push && !s.load);
    endproperty
    a_wake_step: assert property (p_wake_step)
        else $error("vector branch before post-sleep instruction");

    property p_group_gate;
        @(posedge core_clk) disable iff (rst)
        (s.st == CIC_IDLE && !core_req && !s.ctrl[`CIC_BIT_PERIPHERAL_GROUP_ENABLE]
            && !ext_edge && !s.sleep_prev && !return_from_service)
        |=> !s.flush;
    endproperty
    a_group_gate: assert property (p_group_gate)
        else $error("peripheral redirect without group enable");

    property p_unimpl;
        @(posedge core_clk) disable iff (rst)
        (s.pr2[3:1] == 3'h0) && (s.pe2[3:1] == 3'h0);
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("unimplemented bits of set two not zero");

    property p_wake_only_sleep;
        @(posedge core_clk) disable iff (rst)
        wake_request |-> sleep_active && (
            (s.ctrl[`CIC_BIT_EXIE] && s.ctrl[`CIC_BIT_EXIF])
            || (s.ctrl[`CIC_BIT_PBIE] && s.ctrl[`CIC_BIT_PBIF])
            || (s.ctrl[`CIC_BIT_PERIPHERAL_GROUP_ENABLE] && |(s.pe1[6:0] & s.pr1[6:0])));
    endproperty
    a_wake_only_sleep: assert property (p_wake_only_sleep)
        else $error("wake request outside sleep");

    property p_bus_wait;
        @(posedge core_clk) disable iff (rst)
        ($rose(avs_read) && !s.ack) |-> avs_waitrequest ##1 !avs_waitrequest;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("bus answer not after one wait state");

    property p_async_latency;
        @(posedge core_clk) disable iff (rst)
        (ext_edge && s.ctrl[`CIC_BIT_GIE] && s.ctrl[`CIC_BIT_EXIE]
            && s.st == CIC_IDLE && !return_from_service
            && !sleep_active && !s.sleep_prev)
        |=> s.flush ##1 (s.load && s.load_val == `CIC_VECTOR);
    endproperty
    a_async_latency: assert property (p_async_latency)
        else $error("asynchronous latency out of range");

    property p_pending_taken;
        @(posedge core_clk) disable iff (rst)
        (!s.ctrl[`CIC_BIT_GIE] && core_req && s.st == CIC_IDLE)
        ##1 (s.ctrl[`CIC_BIT_GIE] && core_req && s.st == CIC_IDLE
            && !return_from_service && !sleep_active && !s.sleep_prev)
        |=> s.flush;
    endproperty
    a_pending_taken: assert property (p_pending_taken)
        else $error("pending request not taken after enable");

    // No disable clause here: this one has to watch the reset itself.
    property p_reset_clear;
        @(posedge core_clk)
        rst |=> (!s.ctrl[`CIC_BIT_GIE] && !s.flush && !s.load);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("reset left interrupts enabled");

    property p_push_value;
        @(posedge core_clk) disable iff (rst)
        s.push |-> s.push_val == $past(current_pc);
    endproperty
    a_push_value: assert property (p_push_value)
        else $error("pushed address is not the interrupted pc");

    property p_ext_flag;
        @(posedge core_clk) disable iff (rst)
        ext_edge |=> s.ctrl[`CIC_BIT_EXIF];
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("external edge not recorded in its flag");
endmodule : cic_core_interrupt_controller

// ---- cic_seq_model.sv ----
// Purpose: Stack and return model standing beside the controller.
// Assumes: The bench commands each return; pushes come from the controller.
// Notes: Pop data toggles when not valid, so a stale value cannot match.
`timescale 1ns/1ps
module cic_seq_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Bench command
    input wire logic ret_cmd,
    // Controller side
    input wire logic stack_push,
    input wire logic [12:0] stack_push_addr,
    output logic return_from_service,
    output logic [12:0] stack_pop_addr
);
    logic [12:0] stk[$];

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            return_from_service <= 1'b0;
            stack_pop_addr <= 13'h0000;
            stk.delete();
        end else begin
            return_from_service <= 1'b0;
            stack_pop_addr <= ~stack_pop_addr;
            if (stack_push === 1'b1) begin
                stk.push_back(stack_push_addr);
            end
            if (ret_cmd && stk.size() > 0) begin
                return_from_service <= 1'b1;
                stack_pop_addr <= stk.pop_back();
            end
        end
    end
endmodule : cic_seq_model

// ---- cic_core_interrupt_controller_tb_top.sv ----
// Purpose: Self-checking bench for the interrupt controller.
// Assumes: One wait state per bus access; event inputs pulse for one cycle, pins hold levels.
// Notes: A monitor pops queued expectations as reads and PC loads occur.
`timescale 1ns/1ps
module cic_core_interrupt_controller_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timer0_ovf_event = 1'b0;
    logic external_request_pin = 1'b0;
    logic [7:0] portb_pins = 8'h00;
    logic [7:0] periph_event_one = 8'h00;
    logic [7:0] periph_event_two = 8'h00;
    logic [12:0] current_pc = 13'h0000;
    logic return_from_service;
    logic [12:0] stack_pop_addr;
    logic flush_prefetch;
    logic stack_push;
    logic [12:0] stack_push_addr;
    logic pc_load;
    logic [12:0] pc_load_value;
    logic sleep_active = 1'b0;
    logic wake_request;
    logic ret_cmd = 1'b0;
    logic [31:0] exp_rd[$];
    logic [31:0] exp_pc[$];
    logic [7:0] d;
    logic [12:0] pcv;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int ev_cyc = 0;
    int fl_cyc = 0;
    bit lat_on = 1'b0;

    always #20 core_clk = ~core_clk;

    cic_core_interrupt_controller u_cic_core_interrupt_controller (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .timer0_ovf_event(timer0_ovf_event),
        .external_request_pin(external_request_pin),
        .portb_pins(portb_pins), .periph_event_one(periph_event_one),
        .periph_event_two(periph_event_two), .current_pc(current_pc),
        .return_from_service(return_from_service),
        .stack_pop_addr(stack_pop_addr), .flush_prefetch(flush_prefetch),
        .stack_push(stack_push), .stack_push_addr(stack_push_addr),
        .pc_load(pc_load), .pc_load_value(pc_load_value),
        .sleep_active(sleep_active), .wake_request(wake_request)
    );

    cic_seq_model u_cic_seq_model (
        .core_clk(core_clk), .rst(rst), .ret_cmd(ret_cmd),
        .stack_push(stack_push), .stack_push_addr(stack_push_addr),
        .return_from_service(return_from_service),
        .stack_pop_addr(stack_pop_addr)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // The request is held until waitrequest is sampled low at an edge.
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v);
        @(posedge core_clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= {24'h0, v};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_rd.push_back({24'h0, e});
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        bus(1'b1, a, v);
    endtask : wr

    task automatic wait_pc();
        for (int n = 0; n < 30 && exp_pc.size() > 0; n++) @(posedge core_clk);
        check(32'(exp_pc.size()), 32'h0);
    endtask : wait_pc

    // A vector load that nobody announced is a fault in itself.
    always @(posedge core_clk) begin
        cyc++;
        if (timer0_ovf_event === 1'b1) ev_cyc = cyc;
        if (flush_prefetch === 1'b1) fl_cyc = cyc;
        if (stack_push === 1'b1) check(32'(cyc - fl_cyc), 32'h1);
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (exp_rd.size() > 0) check(avs_readdata, exp_rd.pop_front());
        end
        if (pc_load === 1'b1) begin
            if (lat_on) check(32'(cyc - ev_cyc), 32'h3);
            lat_on = 1'b0;
            if (exp_pc.size() > 0) begin
                check({19'h0, pc_load_value}, exp_pc.pop_front());
            end else begin
                check({19'h0, pc_load_value}, 32'hffffffff);
            end
        end
        if (cyc == 3000) begin
            n_errors++;
            results();
        end
    end

    initial begin
        void'($urandom(63));
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) rd(5'(i * 4), 8'h00);
        rd(5'h18, 8'h01);
        rd(5'h03, 8'h00);
        d = 8'($urandom) & 8'h7f;
        wr(5'h00, d);
        rd(5'h00, d);
        wr(5'h08, 8'hff);
        rd(5'h08, 8'hf1);
        wr(5'h04, d);
        rd(5'h04, d);
        avs_byteenable <= 4'h0;
        wr(5'h00, 8'h00);
        avs_byteenable <= 4'h1;
        rd(5'h00, d);
        wr(5'h00, 8'h00);
        wr(5'h04, 8'h00);
        wr(5'h08, 8'h00);
        periph_event_one <= 8'hff;
        periph_event_two <= 8'hff;
        timer0_ovf_event <= 1'b1;
        @(posedge core_clk);
        periph_event_one <= 8'h00;
        periph_event_two <= 8'h00;
        timer0_ovf_event <= 1'b0;
        rd(5'h0c, 8'hff);
        rd(5'h10, 8'hf1);
        rd(5'h00, 8'h04);
        wr(5'h04, 8'h01);
        wr(5'h00, 8'h80);
        repeat (8) @(posedge core_clk);
        exp_pc.push_back(32'h0004);
        wr(5'h00, 8'hc0);
        wait_pc();
        wr(5'h0c, 8'h00);
        wr(5'h00, 8'h00);
        wr(5'h04, 8'h00);
        pcv = 13'($urandom);
        current_pc <= pcv;
        wr(5'h00, 8'ha0);
        lat_on = 1'b1;
        exp_pc.push_back(32'h0004);
        timer0_ovf_event <= 1'b1;
        @(posedge core_clk);
        timer0_ovf_event <= 1'b0;
        wait_pc();
        exp_pc.push_back({19'h0, pcv});
        exp_pc.push_back(32'h0004);
        ret_cmd <= 1'b1;
        @(posedge core_clk);
        ret_cmd <= 1'b0;
        wait_pc();
        rd(5'h00, 8'h24);
        wr(5'h00, 8'h00);
        external_request_pin <= 1'b1;
        repeat (5) @(posedge core_clk);
        rd(5'h00, 8'h02);
        wr(5'h00, 8'h00);
        external_request_pin <= 1'b0;
        repeat (5) @(posedge core_clk);
        rd(5'h00, 8'h00);
        wr(5'h18, 8'h00);
        external_request_pin <= 1'b1;
        repeat (5) @(posedge core_clk);
        rd(5'h00, 8'h00);
        wr(5'h00, 8'h90);
        exp_pc.push_back(32'h0004);
        external_request_pin <= 1'b0;
        wait_pc();
        rd(5'h00, 8'h12);
        wr(5'h00, 8'h00);
        wr(5'h14, 8'h04);
        sleep_active <= 1'b1;
        wr(5'h00, 8'h88);
        portb_pins <= 8'h02;
        repeat (5) @(posedge core_clk);
        check({31'h0, wake_request}, 32'h0);
        portb_pins <= 8'h06;
        repeat (5) @(posedge core_clk);
        check({31'h0, wake_request}, 32'h1);
        rd(5'h1c, 8'h03);
        exp_pc.push_back(32'h0004);
        sleep_active <= 1'b0;
        wait_pc();
        rd(5'h00, 8'h09);
        wr(5'h00, 8'h80);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        rd(5'h00, 8'h00);
        rd(5'h18, 8'h01);
        results();
    end
endmodule : cic_core_interrupt_controller_tb_top
